// File: verilog/ptc_pkg.sv
// constants, register map and pattern codes of the prbs test control block
package ptc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ELAPSED_TICK_S = 2;
  localparam int unsigned ELAPSED_TICK_CYCLES = ELAPSED_TICK_S * CLK_HZ;

  localparam int unsigned WB_ADR_W = 18;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned REG_W = 16;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_L0_CTRL = 16'hf030;
  localparam logic [15:0] IDX_L0_ERR_LO = 16'hf037;
  localparam logic [15:0] IDX_L0_ELAPSED = 16'hf03a;
  localparam logic [15:0] IDX_L1_CTRL = 16'hf040;
  localparam logic [15:0] IDX_L1_TX_LO = 16'hf041;
  localparam logic [15:0] IDX_L1_TX_MID = 16'hf042;
  localparam logic [15:0] IDX_L1_TX_HI = 16'hf043;
  localparam logic [15:0] IDX_L1_ERR_LO = 16'hf047;

  // control register fields of lane 1; lane 0 uses only the average, clear-on-read, counter reset and receive enable bits
  localparam int unsigned CTL_AVG_BIT = 14;
  localparam int unsigned CTL_COR_BIT = 13;
  localparam int unsigned CTL_LOCK_BIT = 8;
  localparam int unsigned CTL_IMM_BIT = 7;
  localparam int unsigned CTL_CRST_BIT = 6;
  localparam int unsigned CTL_TXEN_BIT = 5;
  localparam int unsigned CTL_RXEN_BIT = 4;
  localparam int unsigned CTL_PAT_LSB = 0;
  localparam int unsigned CTL_PAT_W = 4;

  localparam logic CTL_AVG_RST = 1'b1;
  localparam logic CTL_COR_RST = 1'b0;
  localparam logic CTL_FLAG_RST = 1'b0;
  localparam logic [15:0] CNT_RST = 16'h0000;

  localparam int unsigned TX_CNT_W = 48;
  localparam int unsigned ERR_CNT_W = 16;

  typedef enum logic [3:0] {
    PTC_PRBS31 = 4'b0000,
    PTC_PRBS7 = 4'b0001,
    PTC_PRBS9 = 4'b0010,
    PTC_PRBS23 = 4'b0011,
    PTC_PRBS31_INV = 4'b0100,
    PTC_PRBS7_INV = 4'b0101,
    PTC_PRBS9_INV = 4'b0110,
    PTC_PRBS23_INV = 4'b0111,
    PTC_PRBS15 = 4'b1000,
    PTC_PRBS15_INV = 4'b1001,
    PTC_UNUSED_A = 4'b1010,
    PTC_UNUSED_B = 4'b1011,
    PTC_HIGH_FREQ = 4'b1100,
    PTC_LOW_FREQ = 4'b1101,
    PTC_MIXED_FREQ = 4'b1110,
    PTC_SQUARE = 4'b1111
  } ptc_pattern_t;
endpackage : ptc_pkg

// File: verilog/ptc_counter.sv
// event counter with synchronous clear; an event in the clear cycle counts
`timescale 1ns/100ps
module ptc_counter #(
  parameter int unsigned W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [W-1:0] cnt_o
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (clr_i) begin
      // set wins over clear so no event is lost
      cnt_r <= inc_i ? W'(1) : '0;
    end else if (inc_i) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign cnt_o = cnt_r;
endmodule : ptc_counter

// File: verilog/ptc_top.sv
// prbs test control: control registers and counters behind a wishbone slave
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
module ptc_top #(
  parameter int unsigned TICK_CYCLES = ptc_pkg::ELAPSED_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptc_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ptc_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [ptc_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_bit_i,
  input wire logic rx_bit_err_i,
  input wire logic rx_lock_i,
  input wire logic lane0_bit_err_i,
  output ptc_pkg::ptc_pattern_t pattern_sel_o,
  output logic tx_gen_en_o,
  output logic rx_chk_en_o,
  output logic avg_accumulate_o
);
  import ptc_pkg::*;

  localparam int unsigned PW = $clog2(TICK_CYCLES);

  // bus decode
  logic ack_r;
  logic [WB_DAT_W-1:0] dat_r;
  logic req;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] rdata;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign idx = wb_adr_i[WB_ADR_W-1:2];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // lane 1 control
  logic avg_r;
  logic cor_r;
  logic imm_r;
  logic crst_r;
  logic txen_r;
  logic rxen_r;
  logic [CTL_PAT_W-1:0] pat_r;
  // lane 0 control
  logic l0_avg_r;
  logic l0_cor_r;
  logic l0_crst_r;
  logic l0_run_r;

  logic [REG_W-1:0] l1_ctl_rd;
  logic [REG_W-1:0] l1_ctl_old;
  logic [REG_W-1:0] l1_ctl_nxt;
  logic [REG_W-1:0] l0_ctl_rd;
  logic [REG_W-1:0] l0_ctl_nxt;
  logic wr_l1_ctl;
  logic wr_l0_ctl;

  assign wr_l1_ctl = wr & (idx == IDX_L1_CTRL);
  assign wr_l0_ctl = wr & (idx == IDX_L0_CTRL);

  // pattern decode
  logic pat_known;
  logic pat_checkable;
  logic gen_act;
  logic chk_act;
  logic lock_s;

  always_comb begin
    pat_known = 1'b0;
    pat_checkable = 1'b0;
    // same decode at every line rate: no speed input reaches it
    unique case (ptc_pattern_t'(pat_r))
      PTC_PRBS31, PTC_PRBS7, PTC_PRBS9, PTC_PRBS23,
      PTC_PRBS31_INV, PTC_PRBS7_INV, PTC_PRBS9_INV, PTC_PRBS23_INV,
      PTC_PRBS15, PTC_PRBS15_INV: begin
        pat_known = 1'b1;
        pat_checkable = 1'b1;
      end
      PTC_HIGH_FREQ, PTC_LOW_FREQ, PTC_MIXED_FREQ: begin
        pat_known = 1'b1;
        pat_checkable = 1'b0;
      end
      PTC_SQUARE: begin
        pat_known = 1'b1;
        pat_checkable = 1'b1;
      end
      PTC_UNUSED_A, PTC_UNUSED_B: begin
        pat_known = 1'b0;
        pat_checkable = 1'b0;
      end
    endcase
  end

  assign gen_act = txen_r & pat_known;
  assign chk_act = rxen_r & pat_checkable;
  assign lock_s = chk_act & rx_lock_i;

  // write merge under byte enables; reserved bits are not stored
  always_comb begin
    l1_ctl_old = '0;
    l1_ctl_old[CTL_AVG_BIT] = avg_r;
    l1_ctl_old[CTL_COR_BIT] = cor_r;
    l1_ctl_old[CTL_IMM_BIT] = imm_r;
    l1_ctl_old[CTL_TXEN_BIT] = txen_r;
    l1_ctl_old[CTL_RXEN_BIT] = rxen_r;
    l1_ctl_old[CTL_PAT_LSB +: CTL_PAT_W] = pat_r;
    l1_ctl_nxt = (wb_dat_i[REG_W-1:0] & wmask) | (l1_ctl_old & ~wmask);
    l1_ctl_rd = l1_ctl_old;
    l1_ctl_rd[CTL_LOCK_BIT] = lock_s;
    l1_ctl_rd[CTL_CRST_BIT] = crst_r;
  end

  always_comb begin
    l0_ctl_rd = '0;
    l0_ctl_rd[CTL_AVG_BIT] = l0_avg_r;
    l0_ctl_rd[CTL_COR_BIT] = l0_cor_r;
    l0_ctl_rd[CTL_CRST_BIT] = l0_crst_r;
    l0_ctl_rd[CTL_RXEN_BIT] = l0_run_r;
    l0_ctl_nxt = (wb_dat_i[REG_W-1:0] & wmask) | (l0_ctl_rd & ~wmask);
  end

  // lane 1 control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avg_r <= CTL_AVG_RST;
      cor_r <= CTL_COR_RST;
      imm_r <= CTL_FLAG_RST;
      txen_r <= CTL_FLAG_RST;
      rxen_r <= CTL_FLAG_RST;
      pat_r <= '0;
    end else if (soft_rst_i) begin
      // clear-on-read survives a software reset
      avg_r <= CTL_AVG_RST;
      imm_r <= CTL_FLAG_RST;
      txen_r <= CTL_FLAG_RST;
      rxen_r <= CTL_FLAG_RST;
      pat_r <= '0;
    end else if (wr_l1_ctl) begin
      avg_r <= l1_ctl_nxt[CTL_AVG_BIT];
      cor_r <= l1_ctl_nxt[CTL_COR_BIT];
      imm_r <= l1_ctl_nxt[CTL_IMM_BIT];
      txen_r <= l1_ctl_nxt[CTL_TXEN_BIT];
      rxen_r <= l1_ctl_nxt[CTL_RXEN_BIT];
      pat_r <= l1_ctl_nxt[CTL_PAT_LSB +: CTL_PAT_W];
    end
  end

  // counter reset bits stand one cycle, so every write of one is a rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst_i) begin
      crst_r <= CTL_FLAG_RST;
      l0_crst_r <= CTL_FLAG_RST;
    end else begin
      crst_r <= wr_l1_ctl & l1_ctl_nxt[CTL_CRST_BIT] & ~crst_r;
      l0_crst_r <= wr_l0_ctl & l0_ctl_nxt[CTL_CRST_BIT] & ~l0_crst_r;
    end
  end

  // lane 0 control bits this block needs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      l0_avg_r <= CTL_AVG_RST;
      l0_cor_r <= CTL_COR_RST;
      l0_run_r <= CTL_FLAG_RST;
    end else if (soft_rst_i) begin
      l0_avg_r <= CTL_AVG_RST;
      l0_run_r <= CTL_FLAG_RST;
    end else if (wr_l0_ctl) begin
      l0_avg_r <= l0_ctl_nxt[CTL_AVG_BIT];
      l0_cor_r <= l0_ctl_nxt[CTL_COR_BIT];
      l0_run_r <= l0_ctl_nxt[CTL_RXEN_BIT];
    end
  end

  // lane 1 transmit counter with snapshot of the upper words
  logic [TX_CNT_W-1:0] tx_cnt;
  logic [REG_W-1:0] tx_mid_r;
  logic [REG_W-1:0] tx_hi_r;
  logic rd_tx_lo;
  logic rd_tx_mid;
  logic rd_tx_hi;
  logic l1_clr;
  logic tx_clr;

  assign rd_tx_lo = rd & (idx == IDX_L1_TX_LO);
  assign rd_tx_mid = rd & (idx == IDX_L1_TX_MID);
  assign rd_tx_hi = rd & (idx == IDX_L1_TX_HI);
  assign l1_clr = soft_rst_i | crst_r;
  // with clear-on-read set, a low word read empties the live counter; upper words live on in the snapshot
  assign tx_clr = l1_clr | (cor_r & rd_tx_lo);

  ptc_counter #(
    .W(TX_CNT_W)
  ) u_tx_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(tx_clr),
    .inc_i(gen_act & tx_bit_i),
    .cnt_o(tx_cnt)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i || l1_clr) begin
      tx_mid_r <= CNT_RST;
      tx_hi_r <= CNT_RST;
    end else if (rd_tx_lo) begin
      tx_mid_r <= tx_cnt[31:16];
      tx_hi_r <= tx_cnt[47:32];
    end else begin
      if (cor_r && rd_tx_mid) begin
        tx_mid_r <= CNT_RST;
      end
      if (cor_r && rd_tx_hi) begin
        tx_hi_r <= CNT_RST;
      end
    end
  end

  // lane 1 error counter
  logic [ERR_CNT_W-1:0] err_cnt;
  logic err_inc;

  assign err_inc = chk_act & rx_bit_err_i & (lock_s | imm_r);

  ptc_counter #(
    .W(ERR_CNT_W)
  ) u_err_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(l1_clr | (cor_r & rd & (idx == IDX_L1_ERR_LO))),
    .inc_i(err_inc),
    .cnt_o(err_cnt)
  );

  // lane 0 error count and elapsed timer
  logic l0_clr;
  logic rd_l0_err;
  logic rd_l0_el;
  logic [REG_W-1:0] l0_err_cnt;
  logic [REG_W-1:0] el_cnt;
  logic [REG_W-1:0] el_view_r;
  logic [PW-1:0] pre_r;
  logic tick;
  logic el_run;

  assign l0_clr = soft_rst_i | l0_crst_r;
  assign rd_l0_err = rd & (idx == IDX_L0_ERR_LO);
  assign rd_l0_el = rd & (idx == IDX_L0_ELAPSED);
  // timer stands still unless average accumulation is on
  assign el_run = l0_run_r & l0_avg_r;
  assign tick = el_run & (pre_r == PW'(TICK_CYCLES - 1));

  ptc_counter #(
    .W(REG_W)
  ) u_l0_err_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(l0_clr | (l0_cor_r & rd_l0_err)),
    .inc_i(l0_run_r & lane0_bit_err_i),
    .cnt_o(l0_err_cnt)
  );

  // prescaler gives a one-cycle enable every two seconds
  always_ff @(posedge clk_i) begin
    if (rst_i || l0_clr || !el_run || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  ptc_counter #(
    .W(REG_W)
  ) u_el_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(l0_clr | (l0_cor_r & rd_l0_el)),
    .inc_i(tick),
    .cnt_o(el_cnt)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i || l0_clr) begin
      el_view_r <= CNT_RST;
    end else if (rd_l0_err) begin
      el_view_r <= el_cnt;
    end else if (l0_cor_r && rd_l0_el) begin
      el_view_r <= CNT_RST;
    end
  end

  // read mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    rdata = '0;
    unique case (idx)
      IDX_L0_CTRL: rdata = l0_ctl_rd;
      IDX_L0_ERR_LO: rdata = l0_err_cnt;
      IDX_L0_ELAPSED: rdata = el_view_r;
      IDX_L1_CTRL: rdata = l1_ctl_rd;
      IDX_L1_TX_LO: rdata = tx_cnt[15:0];
      IDX_L1_TX_MID: rdata = tx_mid_r;
      IDX_L1_TX_HI: rdata = tx_hi_r;
      IDX_L1_ERR_LO: rdata = err_cnt;
      default: rdata = '0;
    endcase
  end

  // one wait state: request taken on the edge where ack is low, ack next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req;
      if (rd) begin
        dat_r <= {16'h0000, rdata};
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pattern_sel_o = ptc_pattern_t'(pat_r);
  assign tx_gen_en_o = gen_act;
  assign rx_chk_en_o = chk_act;
  assign avg_accumulate_o = avg_r;
endmodule : ptc_top

// File: tb/ptc_top_assertions.sv
// port assertions for the prbs test control block
`timescale 1ns/100ps
module ptc_top_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptc_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ptc_pkg::WB_DAT_W-1:0] wb_dat_i,
  input wire logic [ptc_pkg::WB_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_lock_i,
  input wire ptc_pkg::ptc_pattern_t pattern_sel_o,
  input wire logic tx_gen_en_o,
  input wire logic rx_chk_en_o,
  input wire logic avg_accumulate_o
);
  import ptc_pkg::*;
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[17:2] == IDX_L1_CTRL;
  wire logic wr_ctl = take && wb_we_i && wb_sel_i[0];
  wire logic rd_ctl = take && !wb_we_i;
  AST_GEN_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_gen_en_o |-> pattern_sel_o[3:1] != 3'b101) else $error("generator on for idle code");
  AST_CHK_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_chk_en_o |-> (pattern_sel_o <= 4'h9 || pattern_sel_o == 4'hf))
    else $error("checker on for unchecked code");
  AST_PAT_WR: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    wr_ctl |=> pattern_sel_o == $past(wb_dat_i[3:0])) else $error("pattern code not taken");
  AST_GEN_WR: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    wr_ctl |=> tx_gen_en_o == ($past(wb_dat_i[5]) && $past(wb_dat_i[3:1]) != 3'b101))
    else $error("generator enable wrong after write");
  AST_CHK_WR: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    wr_ctl |=> rx_chk_en_o == ($past(wb_dat_i[4])
      && ($past(wb_dat_i[3:0]) <= 4'h9 || $past(wb_dat_i[3:0]) == 4'hf)))
    else $error("checker enable wrong after write");
  AST_AVG_RST: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_rst_i |=> avg_accumulate_o) else $error("average mode not set by reset");
  AST_RST_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> pattern_sel_o == PTC_PRBS31 && !tx_gen_en_o && !rx_chk_en_o && !wb_ack_o)
    else $error("outputs not at reset values");
  AST_LOCK_RD: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    rd_ctl |=> wb_dat_o[8] == $past(rx_lock_i && rx_chk_en_o)) else $error("lock bit wrong");
  AST_AVG_RD: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
    rd_ctl |=> wb_dat_o[14] == $past(avg_accumulate_o)) else $error("average bit readback wrong");
endmodule : ptc_top_assertions
bind ptc_top ptc_top_assertions u_ast (.clk_i, .rst_i, .soft_rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_lock_i,
  .pattern_sel_o, .tx_gen_en_o, .rx_chk_en_o, .avg_accumulate_o);

// File: tb/ptc_lane_model.sv
// behavioural serial lane datapath facing the prbs test control block
`timescale 1ns/100ps
module ptc_lane_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chk_en_i,
  input wire logic tx_on_i,
  input wire logic err_on_i,
  input wire logic lock_on_i,
  output logic tx_bit_o,
  output logic rx_err_o,
  output logic rx_lock_o,
  output logic l0_err_o
);
  // errors arrive whatever the checker state, so gating is left to the block
  assign tx_bit_o = tx_on_i;
  assign rx_err_o = err_on_i;
  assign l0_err_o = err_on_i;
  // lock needs a running checker and lags it by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_lock_o <= 1'b0;
    end else begin
      rx_lock_o <= lock_on_i && chk_en_i;
    end
  end
endmodule : ptc_lane_model

// File: tb/ptc_top_tb.sv
// self-checking bench for the prbs test control block
`timescale 1ns/100ps
module ptc_top_tb;
  import ptc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [WB_ADR_W-1:0] adr = '0;
  logic [WB_DAT_W-1:0] wdat = '0;
  logic [WB_DAT_W-1:0] rdat;
  logic ack;
  logic tx_on = 1'b0;
  logic err_on = 1'b0;
  logic lock_on = 1'b0;
  logic tx_bit, rx_err, rx_lock, l0_err, gen_en, chk_en, avg;
  ptc_pattern_t pat;
  logic [15:0] v;
  logic [15:0] e;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  ptc_top #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_bit_i(tx_bit), .rx_bit_err_i(rx_err),
    .rx_lock_i(rx_lock), .lane0_bit_err_i(l0_err), .pattern_sel_o(pat), .tx_gen_en_o(gen_en),
    .rx_chk_en_o(chk_en), .avg_accumulate_o(avg));
  ptc_lane_model u_lane (.clk_i(clk_i), .rst_i(rst_i), .chk_en_i(chk_en), .tx_on_i(tx_on),
    .err_on_i(err_on), .lock_on_i(lock_on), .tx_bit_o(tx_bit), .rx_err_o(rx_err),
    .rx_lock_o(rx_lock), .l0_err_o(l0_err));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // the whole run is about 66k cycles, dominated by the long transmit burst
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // classic cycle: ack and data are sampled at the rising edge, the request drops there
  // no wait limit here: a hung slave is caught by the cycle ceiling
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                    output logic [15:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    chk(ack, 1'b0);
  endtask : wb
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr
  task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    wb(1'b0, idx, 16'h0000, q);
    chk(q, exp);
  endtask : rdchk
  task automatic burst(input int n, input logic on_tx);
    if (on_tx) tx_on <= 1'b1;
    else err_on <= 1'b1;
    repeat (n) @(posedge clk_i);
    tx_on <= 1'b0;
    err_on <= 1'b0;
  endtask : burst
  task automatic t_reset();
    chk(avg, 1'b1);
    rdchk(IDX_L1_CTRL, 16'h4000);
    wr(IDX_L1_CTRL, 16'h0000);
    chk(avg, 1'b0);
    rdchk(IDX_L1_CTRL, 16'h0000);
    rdchk(IDX_L1_TX_LO, 16'h0000);
    rdchk(IDX_L0_ELAPSED, 16'h0000);
    wr(16'hf050, 16'hffff);
    rdchk(16'hf050, 16'h0000);
  endtask : t_reset
  task automatic t_codes();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      wr(IDX_L1_CTRL, 16'h4030 | c);
      chk(pat, c);
      chk(gen_en, c[3:1] != 3'b101);
      chk(chk_en, c <= 4'h9 || c == 4'hf);
    end
  endtask : t_codes
  task automatic t_tx();
    wr(IDX_L1_CTRL, 16'h4020);
    burst(65538, 1'b1);
    rdchk(IDX_L1_TX_MID, 16'h0000);
    rdchk(IDX_L1_TX_LO, 16'h0002);
    rdchk(IDX_L1_TX_MID, 16'h0001);
    rdchk(IDX_L1_TX_LO, 16'h0002);
    wr(IDX_L1_CTRL, 16'h4060);
    rdchk(IDX_L1_CTRL, 16'h4020);
    rdchk(IDX_L1_TX_LO, 16'h0000);
    wr(IDX_L1_CTRL, 16'h6020);
    burst(3, 1'b1);
    rdchk(IDX_L1_TX_LO, 16'h0003);
    rdchk(IDX_L1_TX_LO, 16'h0000);
    burst(2, 1'b1);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(IDX_L1_CTRL, 16'h6000);
    rdchk(IDX_L1_TX_LO, 16'h0000);
  endtask : t_tx
  task automatic t_err();
    wr(IDX_L1_CTRL, 16'h4010);
    burst(4, 1'b0);
    rdchk(IDX_L1_ERR_LO, 16'h0000);
    wr(IDX_L1_CTRL, 16'h4090);
    burst(4, 1'b0);
    rdchk(IDX_L1_ERR_LO, 16'h0004);
    lock_on <= 1'b1;
    wr(IDX_L1_CTRL, 16'h4010);
    burst(2, 1'b0);
    rdchk(IDX_L1_ERR_LO, 16'h0006);
    rdchk(IDX_L1_CTRL, 16'h4110);
    lock_on <= 1'b0;
  endtask : t_err
  task automatic t_elapsed();
    wr(IDX_L0_CTRL, 16'h4010);
    repeat (40) @(posedge clk_i);
    wr(IDX_L0_CTRL, 16'h4000);
    rdchk(IDX_L0_ELAPSED, 16'h0000);
    wb(1'b0, IDX_L0_ERR_LO, 16'h0000, v);
    wb(1'b0, IDX_L0_ELAPSED, 16'h0000, e);
    chk(e >= 16'd10 && e <= 16'd11, 1'b1);
    wb(1'b0, IDX_L0_ERR_LO, 16'h0000, v);
    rdchk(IDX_L0_ELAPSED, e);
    wr(IDX_L0_CTRL, 16'h4040);
    wb(1'b0, IDX_L0_ERR_LO, 16'h0000, v);
    rdchk(IDX_L0_ELAPSED, 16'h0000);
    wr(IDX_L0_CTRL, 16'h0010);
    repeat (20) @(posedge clk_i);
    wr(IDX_L0_CTRL, 16'h4000);
    wb(1'b0, IDX_L0_ERR_LO, 16'h0000, v);
    rdchk(IDX_L0_ELAPSED, 16'h0000);
    wr(IDX_L0_CTRL, 16'h6010);
    repeat (20) @(posedge clk_i);
    wr(IDX_L0_CTRL, 16'h6000);
    wb(1'b0, IDX_L0_ERR_LO, 16'h0000, v);
    wb(1'b0, IDX_L0_ELAPSED, 16'h0000, e);
    chk(e != 16'h0000, 1'b1);
    wb(1'b0, IDX_L0_ERR_LO, 16'h0000, v);
    rdchk(IDX_L0_ELAPSED, 16'h0000);
  endtask : t_elapsed
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_codes();
    t_tx();
    t_err();
    t_elapsed();
    wr(IDX_L1_CTRL, 16'h6000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(IDX_L1_CTRL, 16'h4000);
    report_and_stop();
  end
endmodule : ptc_top_tb
